//--- include/aeb_pkg.sv
/*
  aeb_pkg: constants, encodings and timing for the external asynchronous bus master.
  Assumes a single 10 MHz system clock and no software-visible registers.
*/
package aeb_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int RST_HOLD_CLKS = 512;
  localparam int RST_CNT_W = 10;
  localparam logic [RST_CNT_W-1:0] RST_HOLD = 10'(RST_HOLD_CLKS);
  localparam logic [RST_CNT_W-1:0] RST_ZERO = 10'h000;
  localparam int CS_N = 4;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam logic [3:0] FC_USER_DATA = 4'h1;
  localparam logic [3:0] FC_USER_PROG = 4'h2;
  localparam logic [3:0] FC_SUP_DATA = 4'h5;
  localparam logic [3:0] FC_SUP_PROG = 4'h6;
  localparam logic [3:0] FC_CPU = 4'h7;
  localparam int FC_DMA_BIT = 3;
  localparam logic [1:0] SZ_LONG = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_WORD = 2'h2;
  localparam logic [1:0] SZ_THREE = 2'h3;
  // data_size_ack pair {one,zero}, active low
  localparam logic [1:0] ACK_WAIT = 2'h3;
  localparam logic [1:0] ACK_8 = 2'h2;
  localparam logic [1:0] ACK_16 = 2'h1;
  localparam logic [1:0] ACK_RSVD = 2'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 32'h00000000;
  localparam logic [CS_N-1:0] CS_IDLE = 4'hF;
  localparam logic [CS_N-1:0] CS_BOOT = 4'hE;
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_S1 = 8'h02,
    ST_WAIT = 8'h04,
    ST_DSW = 8'h08,
    ST_END = 8'h10,
    ST_GRANT = 8'h20,
    ST_OWNED = 8'h40,
    ST_HALT = 8'h80
  } aeb_state_t;
endpackage

//--- verilog/aeb_bus_master.sv
/*
  aeb_bus_master: external asynchronous bus master with dynamic sizing, arbitration,
  locked cycles, reset/halt/fault handling and clock-mode strap capture.
  Assumes inputs are synchronous to clock; open-drain pins split into in/out/oe.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - each cycle moves one or two bytes over sixteen data lines
// - read data captured at the last falling clock edge of the cycle
// - writes drive all sixteen data lines regardless of port or operand
// - write data appears half a clock after address_strobe
// - four-bit space_code names user, supervisor, CPU or DMA space
// - space_code holds steady while address_strobe is asserted
// - chip_sel zero is boot select and is asserted from reset; the other chip_sel lines idle high
// - data_size_ack pair selects wait, 8-bit, 16-bit; both means 16-bit
// - asserted acknowledge latches read data or confirms write stored
// - address_strobe asserted half a clock after cycle begins
// - read cycles assert data_strobe together with address_strobe
// - write cycles assert data_strobe one clock after address_strobe
// - xfer_bytes_left shows operand bytes remaining: byte, word, three, long
// - direction high for read, low for write
// - bus_req_in, grant_out, master_taken_ack hand over bus ownership
// - locked_cycle held through read-modify-write; no handover meanwhile
// - self-driven reset line held low for at least 512 clocks
// - external reset resets all; software reset spares core and config
// - suspend_line stalls bus; device drives it on double bus fault
// - clk_src_select sampled at reset chooses crystal or external clock
// - auto_vector_req during interrupt acknowledge selects automatic vector
// - address valid from cycle start while address_strobe is asserted
module aeb_bus_master (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic reqValid,
  output logic reqReady,
  input wire logic reqRead,
  input wire logic reqLocked,
  input wire logic reqIntAck,
  input wire logic [aeb_pkg::ADDR_W-1:0] reqAddr,
  input wire logic [3:0] reqSpace,
  input wire logic [1:0] reqBytesLeft,
  input wire logic [aeb_pkg::DATA_W-1:0] reqWrData,
  input wire logic [aeb_pkg::CS_N-1:0] reqChipSel,
  output logic rspValid,
  output logic [aeb_pkg::DATA_W-1:0] rspData,
  output logic rspPort8,
  output logic rspFault,
  output logic rspAutoVector,
  input wire logic softResetReq,
  input wire logic doubleFault,
  output logic moduleReset,
  output logic coreReset,
  output logic crystalMode,
  output logic [aeb_pkg::ADDR_W-1:0] addrOut,
  output logic addrOe,
  output logic [3:0] space_code,
  output logic [1:0] xfer_bytes_left,
  output logic readNotWrite,
  output logic address_strobe_n,
  output logic data_strobe_n,
  output logic [aeb_pkg::CS_N-1:0] chip_sel_n,
  input wire logic [aeb_pkg::DATA_W-1:0] data_lines_in,
  output logic [aeb_pkg::DATA_W-1:0] data_lines_out,
  output logic data_lines_oe,
  input wire logic data_size_ack_one_n,
  input wire logic data_size_ack_zero_n,
  input wire logic fault_in_n,
  input wire logic suspend_line_in_n,
  output logic suspend_line_out,
  output logic suspend_line_oe,
  input wire logic reset_line_in_n,
  output logic reset_line_out,
  output logic reset_line_oe,
  input wire logic bus_req_in_n,
  output logic grant_out_n,
  input wire logic master_taken_ack_n,
  output logic locked_cycle_n,
  input wire logic auto_vector_req_n,
  input wire logic clk_src_select
);
  import aeb_pkg::*;

  // ------------------------------------------------------------
  // state and registers
  // ------------------------------------------------------------
  aeb_state_t state, next_state;
  logic cycRead, cycIntAck, asNeg, dsNeg, doDrive, lockHold;
  logic [RST_CNT_W-1:0] rstCnt;
  logic extResetSeen, strapDone;
  logic [DATA_W-1:0] capData;
  logic capPort8, capFault, capAv, capValid, retryHeld;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire [1:0] ackCode = {data_size_ack_one_n, data_size_ack_zero_n};
  wire ackSeen = (ackCode != ACK_WAIT);
  wire ackIs8 = (ackCode == ACK_8);
  wire faultSeen = !fault_in_n;
  wire retrySeen = faultSeen && !suspend_line_in_n;
  wire avSeen = cycIntAck && !auto_vector_req_n;
  wire endSeen = ackSeen || faultSeen || avSeen;
  wire resetBusy = (rstCnt != RST_ZERO);
  wire extReset = !reset_line_in_n && !reset_line_oe;
  // suspend stalls new cycles and bus grants; a cycle in flight runs to its end
  wire stallNew = !suspend_line_in_n || resetBusy || extReset;
  wire busReqSeen = !bus_req_in_n;
  wire startOk = reqValid && !stallNew && !busReqSeen;
  wire wantGrant = busReqSeen && !lockHold && !(reqValid && reqLocked);
  wire inCycle = (state == ST_S1) || (state == ST_WAIT) || (state == ST_DSW);

  assign reqReady = (state == ST_IDLE) && startOk && (lockHold || !wantGrant);
  assign rspValid = capValid;
  assign rspData = capData;
  assign rspPort8 = capPort8;
  assign rspFault = capFault;
  assign rspAutoVector = capAv;
  assign address_strobe_n = asNeg;
  assign data_strobe_n = dsNeg;
  assign grant_out_n = !((state == ST_GRANT) || (state == ST_OWNED));
  assign suspend_line_out = 1'b0;
  assign suspend_line_oe = (state == ST_HALT);
  assign reset_line_out = 1'b0;
  assign reset_line_oe = resetBusy;
  assign coreReset = extReset;
  assign moduleReset = resetBusy || extReset;
  assign locked_cycle_n = !lockHold;

  // ------------------------------------------------------------
  // cycle sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (doubleFault) begin
          next_state = ST_HALT;
        end else if (wantGrant && !stallNew) begin
          next_state = ST_GRANT;
        end else if (reqReady) begin
          next_state = ST_S1;
        end
      end
      ST_S1: next_state = cycRead ? ST_WAIT : ST_DSW;
      ST_DSW: next_state = ST_WAIT;
      ST_WAIT: begin
        if (endSeen) begin
          next_state = ST_END;
        end
      end
      ST_END: next_state = ST_IDLE;
      ST_GRANT: begin
        if (!master_taken_ack_n) begin
          next_state = ST_OWNED;
        end else if (!busReqSeen) begin
          next_state = ST_IDLE;
        end
      end
      ST_OWNED: begin
        if (master_taken_ack_n && !busReqSeen) begin
          next_state = ST_IDLE;
        end
      end
      ST_HALT: next_state = ST_HALT;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else if (extReset) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // address, space, size, direction latched at cycle start
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addrOut <= ADDR_ZERO;
      space_code <= FC_SUP_PROG;
      xfer_bytes_left <= SZ_WORD;
      readNotWrite <= 1'b1;
      chip_sel_n <= CS_BOOT;
      cycRead <= 1'b1;
      cycIntAck <= 1'b0;
      addrOe <= 1'b0;
      data_lines_out <= DATA_ZERO;
    end else if (reqReady) begin
      addrOut <= reqAddr;
      space_code <= reqSpace;
      xfer_bytes_left <= reqBytesLeft;
      readNotWrite <= reqRead;
      chip_sel_n <= reqChipSel;
      cycRead <= reqRead;
      cycIntAck <= reqIntAck;
      addrOe <= 1'b1;
      data_lines_out <= reqWrData;
    end else if (state == ST_GRANT) begin
      addrOe <= 1'b0;
      chip_sel_n <= CS_IDLE;
    end
  end

  // ------------------------------------------------------------
  // strobes on the falling edge: half a clock into each phase
  // ------------------------------------------------------------
  always_ff @(negedge clock or negedge arst_n) begin
    if (!arst_n) begin
      asNeg <= 1'b1;
      dsNeg <= 1'b1;
    end else begin
      asNeg <= !inCycle;
      dsNeg <= !(inCycle && (cycRead || state != ST_S1));
    end
  end

  // write data follows on the rising edge, half a clock behind address_strobe
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      doDrive <= 1'b0;
    end else begin
      doDrive <= inCycle && !cycRead;
    end
  end
  assign data_lines_oe = doDrive;

  // read data captured on the last falling edge of the cycle
  always_ff @(negedge clock or negedge arst_n) begin
    if (!arst_n) begin
      capData <= DATA_ZERO;
      capPort8 <= 1'b0;
      capFault <= 1'b0;
      capAv <= 1'b0;
    end else if (state == ST_WAIT && endSeen) begin
      capData <= cycRead ? data_lines_in : capData;
      capPort8 <= ackIs8;
      capFault <= faultSeen && !retrySeen;
      capAv <= avSeen;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      capValid <= 1'b0;
    end else begin
      // retry leaves the request pending, so no answer is returned
      capValid <= (state == ST_END) && !(capFault == 1'b0 && retryHeld);
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      retryHeld <= 1'b0;
    end else if (state == ST_WAIT && endSeen) begin
      retryHeld <= retrySeen;
    end
  end

  // locked sequence stays owned from first locked cycle until an unlocked request or an idle clock with no request
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lockHold <= 1'b0;
    end else if (reqReady) begin
      lockHold <= reqLocked;
    end else if (state == ST_IDLE && !reqValid) begin
      lockHold <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // reset line drive and clock strap
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstCnt <= RST_ZERO;
    end else if (softResetReq && !resetBusy) begin
      rstCnt <= RST_HOLD;
    end else if (resetBusy) begin
      rstCnt <= rstCnt - 10'h001;
    end
  end

  // strap is caught by a clocked process at the first edge after release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strapDone <= 1'b0;
      crystalMode <= 1'b0;
      extResetSeen <= 1'b0;
    end else begin
      extResetSeen <= extReset;
      if (!strapDone || extResetSeen) begin
        crystalMode <= clk_src_select;
        strapDone <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_RESET_HOLD: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(reset_line_oe) |-> reset_line_oe [*8] ##1 (rstCnt > 10'h1F0))
    else $error("reset line released too early");
  AST_SPACE_STABLE: assert property (@(posedge clock) disable iff (!arst_n)
    (!address_strobe_n && !$past(address_strobe_n)) |-> $stable(space_code))
    else $error("space code changed under address strobe");
  AST_READ_DS: assert property (@(posedge clock) disable iff (!arst_n)
    (readNotWrite && inCycle) |-> (address_strobe_n == data_strobe_n))
    else $error("read strobes not together");
  AST_WRITE_DS: assert property (@(posedge clock) disable iff (!arst_n)
    (state == ST_S1 && !cycRead) |-> (!address_strobe_n && data_strobe_n) ##1 !data_strobe_n)
    else $error("write data strobe not one clock late");
  AST_END_NEG: assert property (@(posedge clock) disable iff (!arst_n)
    (state == ST_END) |=> ##[0:1] (address_strobe_n && data_strobe_n))
    else $error("strobes not negated after acknowledge");
  AST_NO_GRANT_LOCK: assert property (@(posedge clock) disable iff (!arst_n)
    !locked_cycle_n |-> grant_out_n)
    else $error("bus granted during locked sequence");
  AST_WRITE_DRIVE: assert property (@(posedge clock) disable iff (!arst_n)
    (state == ST_WAIT && !cycRead) |-> data_lines_oe)
    else $error("write data not driven");
  AST_GRANT: assert property (@(posedge clock) disable iff (!arst_n)
    (state == ST_GRANT && !master_taken_ack_n) |=> (state == ST_OWNED && !grant_out_n))
    else $error("ownership handover wrong");
  AST_HALT_OUT: assert property (@(posedge clock) disable iff (!arst_n)
    (state == ST_IDLE && doubleFault && !extReset) |=> suspend_line_oe)
    else $error("double fault not reported");
  AST_WRITE_DATA_LATE: assert property (@(posedge clock) disable iff (!arst_n)
    ($fell(address_strobe_n) && !readNotWrite) |-> !data_lines_oe ##1 data_lines_oe)
    else $error("write data not half a clock after address strobe");
  AST_AS_HALF: assert property (@(posedge clock) disable iff (!arst_n)
    $rose(state == ST_S1) |-> ($past(address_strobe_n) && !address_strobe_n))
    else $error("address strobe not half a clock into the cycle");
  AST_ADDR_STABLE: assert property (@(posedge clock) disable iff (!arst_n)
    (!address_strobe_n && !$past(address_strobe_n)) |-> ($stable(addrOut) && $stable(xfer_bytes_left)))
    else $error("address or size changed under address strobe");
  AST_RSP_PULSE: assert property (@(posedge clock) disable iff (!arst_n)
    rspValid |=> !rspValid)
    else $error("response valid longer than one cycle");
endmodule
`default_nettype wire

//--- sim/aeb_mem_model.sv
/*
  aeb_mem_model: responder for the external bus; answers reads and acknowledges writes.
  Assumes inputs from the bus master settle before clock plus one nanosecond.
*/
`timescale 1ns/1ps
`default_nettype none
module aeb_mem_model (
  input wire logic clock,
  input wire logic address_strobe_n,
  input wire logic readNotWrite,
  input wire logic [aeb_pkg::ADDR_W-1:0] addrOut,
  input wire logic [1:0] ackCode,
  input wire logic [3:0] waitCycles,
  output logic [aeb_pkg::DATA_W-1:0] data_lines_in,
  output logic data_size_ack_one_n,
  output logic data_size_ack_zero_n
);
  import aeb_pkg::*;
  // ----------------------------------------
  // response timing
  // ----------------------------------------
  logic [3:0] waitCnt;
  initial begin
    waitCnt = 4'h0;
    data_lines_in = DATA_ZERO;
    {data_size_ack_one_n, data_size_ack_zero_n} = ACK_WAIT;
  end
  // acks stay up until the strobe drops, as an asynchronous slave would
  always @(posedge clock) begin
    #1;
    if (address_strobe_n == 1'b0) begin
      if (readNotWrite == 1'b1) begin
        data_lines_in = addrOut[15:0] ^ 16'hA5C3;
      end
      if (waitCnt >= waitCycles) begin
        {data_size_ack_one_n, data_size_ack_zero_n} = ackCode;
      end
      waitCnt = waitCnt + 4'h1;
    end else begin
      waitCnt = 4'h0;
      {data_size_ack_one_n, data_size_ack_zero_n} = ACK_WAIT;
      // released bus inverts its value on every clock
      data_lines_in = ~data_lines_in;
    end
  end
endmodule
`default_nettype wire

//--- sim/async_external_bus_master_tb.sv
/*
  async_external_bus_master_tb: self-checking bench for the external bus master.
  Assumes the responder model and package are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module async_external_bus_master_tb;
  import aeb_pkg::*;
  typedef struct {logic chk; logic [15:0] data; logic port8; logic fault; logic av;} aeb_exp_t;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clock, arst_n, reqValid, reqRead, reqLocked, reqIntAck, softResetReq, doubleFault;
  logic fault_in_n, bus_req_in_n, master_taken_ack_n, auto_vector_req_n, clk_src_select;
  logic [ADDR_W-1:0] reqAddr, addrOut;
  logic [3:0] reqSpace, waitCycles, space_code;
  logic [1:0] reqBytesLeft, ackCode, xfer_bytes_left;
  logic [DATA_W-1:0] reqWrData, rspData, data_lines_in, data_lines_out;
  logic [CS_N-1:0] reqChipSel, chip_sel_n;
  logic reqReady, rspValid, rspPort8, rspFault, rspAutoVector, moduleReset, coreReset;
  logic crystalMode, addrOe, readNotWrite, address_strobe_n, data_strobe_n, data_lines_oe;
  logic suspend_line_out, suspend_line_oe, reset_line_out, reset_line_oe, grant_out_n;
  logic locked_cycle_n, data_size_ack_one_n, data_size_ack_zero_n;
  logic suspend_line_in_n, reset_line_in_n;
  logic [15:0] rnd = 16'h0040;
  logic [3:0] spaces [6] = '{FC_USER_DATA, FC_USER_PROG, FC_SUP_DATA, FC_SUP_PROG, FC_CPU, 4'h9};
  logic [1:0] acks [3] = '{ACK_8, ACK_16, ACK_RSVD};
  aeb_exp_t expQ [$];
  aeb_exp_t e;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int asCnt = 0;
  int n;
  // open-drain lines with pull-ups
  assign suspend_line_in_n = suspend_line_oe ? suspend_line_out : 1'b1;
  // the board's reset source pulls the shared reset line while arst_n is low
  assign reset_line_in_n = arst_n && !(reset_line_oe && !reset_line_out);
  aeb_bus_master dut (.clock, .arst_n, .reqValid, .reqReady, .reqRead, .reqLocked, .reqIntAck,
    .reqAddr, .reqSpace, .reqBytesLeft, .reqWrData, .reqChipSel, .rspValid, .rspData,
    .rspPort8, .rspFault, .rspAutoVector, .softResetReq, .doubleFault, .moduleReset,
    .coreReset, .crystalMode, .addrOut, .addrOe, .space_code, .xfer_bytes_left,
    .readNotWrite, .address_strobe_n, .data_strobe_n, .chip_sel_n, .data_lines_in,
    .data_lines_out, .data_lines_oe, .data_size_ack_one_n, .data_size_ack_zero_n,
    .fault_in_n, .suspend_line_in_n, .suspend_line_out, .suspend_line_oe, .reset_line_in_n,
    .reset_line_out, .reset_line_oe, .bus_req_in_n, .grant_out_n, .master_taken_ack_n,
    .locked_cycle_n, .auto_vector_req_n, .clk_src_select);
  aeb_mem_model mem (.clock, .address_strobe_n, .readNotWrite, .addrOut, .ackCode,
    .waitCycles, .data_lines_in, .data_size_ack_one_n, .data_size_ack_zero_n);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic doReset(input logic strap);
    clk_src_select = strap;
    arst_n = 1'b0;
    repeat (12) @(posedge clock);
    check(chip_sel_n, CS_BOOT);
    check(address_strobe_n, 1'b1);
    check(coreReset, 1'b1);
    #1;
    arst_n = 1'b1;
    @(posedge clock);
    #1;
    check(crystalMode, strap);
  endtask
  // endKind: 0 responder acks, 1 bus fault, 2 automatic vector
  task automatic issue(input logic rd, input logic lk, input logic [3:0] sp,
      input logic [1:0] sz, input logic [1:0] ack, input int endKind);
    rnd = lfsrNext(rnd);
    reqAddr = {16'h0010, rnd};
    reqChipSel = rnd[2] ? CS_BOOT : 4'hD;
    rnd = lfsrNext(rnd);
    reqWrData = rnd;
    waitCycles = {2'b00, rnd[1:0]};
    reqRead = rd;
    reqLocked = lk;
    reqSpace = sp;
    reqBytesLeft = sz;
    ackCode = ack;
    reqIntAck = (endKind == 2);
    e.chk = rd && endKind == 0;
    e.data = reqAddr[15:0] ^ 16'hA5C3;
    e.port8 = ack == ACK_8 && endKind == 0;
    e.fault = endKind == 1;
    e.av = endKind == 2;
    expQ.push_back(e);
    reqValid = 1'b1;
    n = 0;
    // let the combinational ready settle before looking at it
    #1;
    while (reqReady !== 1'b1 && n < 20) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(reqReady, 1'b1);
    @(posedge clock);
    #1;
    reqValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 40) begin
      @(posedge clock);
      #1;
      n++;
      if (n == 2 && endKind == 1) fault_in_n = 1'b0;
      if (n == 2 && endKind == 2) auto_vector_req_n = 1'b0;
    end
    check(rspValid, 1'b1);
    fault_in_n = 1'b1;
    auto_vector_req_n = 1'b1;
  endtask
  // ----------------------------------------
  // clock, watchdog and output monitor
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end
  always @(posedge clock) begin
    #75;
    if (rspValid === 1'b1) begin
      check(expQ.size() > 0, 1'b1);
      if (expQ.size() > 0) begin
        e = expQ.pop_front();
        if (e.chk) check(rspData, e.data);
        check(rspPort8, e.port8);
        check(rspFault, e.fault);
        check(rspAutoVector, e.av);
      end
      check({address_strobe_n, data_strobe_n}, 2'b11);
    end
    if (address_strobe_n === 1'b0) begin
      asCnt++;
      check(space_code, reqSpace);
      check(addrOut, reqAddr);
      check(xfer_bytes_left, reqBytesLeft);
      check(readNotWrite, reqRead);
      check(chip_sel_n, reqChipSel);
      check(locked_cycle_n, !reqLocked);
      check(grant_out_n, 1'b1);
      check(data_strobe_n, asCnt == 1 && !reqRead);
      if (!reqRead) check({data_lines_oe, data_lines_out}, {asCnt > 1, reqWrData});
    end else begin
      asCnt = 0;
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {reqValid, reqRead, reqLocked, reqIntAck, softResetReq, doubleFault} = 6'h00;
    {fault_in_n, bus_req_in_n, master_taken_ack_n, auto_vector_req_n} = 4'hF;
    {reqAddr, reqSpace, reqBytesLeft, reqWrData} = {ADDR_ZERO, FC_USER_DATA, SZ_WORD, DATA_ZERO};
    {reqChipSel, ackCode, waitCycles} = {CS_IDLE, ACK_16, 4'h0};
    doReset(1'b1);
    $display("test reset done");
    for (int i = 0; i < 12; i++) issue(i[0], 1'b0, spaces[i % 6], i[1:0], acks[i % 3], 0);
    $display("test transfers done");
    issue(1'b1, 1'b1, FC_SUP_DATA, SZ_WORD, ACK_16, 0);
    issue(1'b0, 1'b1, FC_SUP_DATA, SZ_WORD, ACK_16, 0);
    issue(1'b1, 1'b0, FC_SUP_DATA, SZ_WORD, ACK_16, 0);
    issue(1'b1, 1'b0, FC_USER_DATA, SZ_BYTE, ACK_WAIT, 1);
    issue(1'b1, 1'b0, FC_CPU, SZ_BYTE, ACK_WAIT, 2);
    $display("test locked fault vector done");
    bus_req_in_n = 1'b0;
    reqValid = 1'b1;
    n = 0;
    while (grant_out_n !== 1'b0 && n < 8) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(grant_out_n, 1'b0);
    check(reqReady, 1'b0);
    master_taken_ack_n = 1'b0;
    bus_req_in_n = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check(reqReady, 1'b0);
    reqValid = 1'b0;
    master_taken_ack_n = 1'b1;
    repeat (3) @(posedge clock);
    #1;
    check(grant_out_n, 1'b1);
    issue(1'b1, 1'b0, FC_USER_DATA, SZ_WORD, ACK_16, 0);
    $display("test arbitration done");
    softResetReq = 1'b1;
    @(posedge clock);
    #1;
    softResetReq = 1'b0;
    n = 0;
    while (reset_line_oe !== 1'b1 && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    check({moduleReset, coreReset}, 2'b10);
    n = 0;
    while (reset_line_oe === 1'b1 && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(n >= 512, 1'b1);
    $display("test reset drive done");
    doubleFault = 1'b1;
    @(posedge clock);
    #1;
    doubleFault = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    check({suspend_line_oe, reqReady}, 2'b10);
    doReset(1'b0);
    check(suspend_line_oe, 1'b0);
    $display("test halt done");
    results();
  end
endmodule
`default_nettype wire
